// ---- common/ars_pkg.sv ----
// Constants, register map and types for the aux reference and settle block
package ars_pkg;
  // Clock and settle tick timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SETTLE_TICK_NS = 6000;
  localparam int unsigned TICK_CYCLES =
    (SETTLE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_REF = 10'h060;
  localparam logic [9:0] IDX_SETTLE = 10'h061;
  localparam logic [9:0] IDX_CTRL = 10'h070;
  localparam logic [9:0] IDX_STATUS = 10'h071;
  // Field positions
  localparam int unsigned REF_LSB = 0;
  localparam int unsigned SETTLE_LSB = 0;
  localparam int unsigned STATUS_LSB = 0;
  // Values after reset
  localparam logic [5:0] REF_RESET = 6'h00;
  localparam logic [9:0] SETTLE_RESET = 10'h000;
  localparam logic [14:0] CTRL_RESET = 15'h0000;
  // Bus answer codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Bias switch mode codes; upper bit clear means automatic
  localparam logic [1:0] BIAS_FORCE_OFF = 2'h2;
  localparam logic [1:0] BIAS_FORCE_ON = 2'h3;
  // Control register layout, low bit first from aux_en
  typedef struct packed {
    logic [1:0] bias_switch_mode;
    logic two_wire_controller_enable;
    logic [5:0] pin_general_purpose_enable;
    logic [5:0] aux_enable;
  } ars_ctrl_t;
  // Status register layout, low bit first from settling
  typedef struct packed {
    logic [5:0] effective_ref;
    logic bias_on;
    logic hv_refresh;
    logic converting;
    logic settling;
  } ars_status_t;
  // Scan flow states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SETTLE = 3'h2,
    ST_CONVERT = 3'h4
  } ars_state_t;
endpackage

// ---- core/ars_aux_ref_settle.sv ----
// Aux reference selection and preconversion settle control
// What this block does
// - One reference bit per aux channel
// - Selection applies only to enabled channels
// - Reference bit also picks threshold set
// - Pin mode enable overrides bit, readback kept
// - Two-wire enable overrides channels zero, one
// - Settle time is field times 6 us
// - Settle interval precedes a scan's conversions unless field is zero
// - Charge pump refresh during idle settling
// - Auto bias drives from acquisition start
// - Bias mode: auto, forced off, forced on
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ars_aux_ref_settle
  import ars_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Scan sequencer
  input wire logic scan_request_i,
  input wire logic scan_done_i,
  input wire logic meas_active_i,
  output logic convert_go_o,
  output logic settle_busy_o,
  output logic high_voltage_charge_pump_o,
  // Analog controls
  output logic thermistor_bias_output_o,
  output logic [5:0] channel_reference_choice_o,
  output logic [5:0] threshold_set_abs_o
);
  // Software registers
  logic [5:0] ref_sel; // Written reference bits
  logic [5:0] next_ref_sel;
  logic [9:0] settle_interval_count; // Settle field
  logic [9:0] next_settle_interval_count;
  ars_ctrl_t ctrl; // Enables and bias mode
  ars_ctrl_t next_ctrl;
  // Write channel state
  logic aw_held;
  logic next_aw_held;
  logic [9:0] aw_idx; // Held word index
  logic [9:0] next_aw_idx;
  logic w_held;
  logic next_w_held;
  logic [15:0] w_data; // Held low half of data
  logic [15:0] next_w_data;
  logic [1:0] w_strb; // Held low byte lanes
  logic [1:0] next_w_strb;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  // Read channel state
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  // Scan flow
  ars_state_t state;
  ars_state_t next_state;
  logic timer_start;
  logic timer_busy;
  logic timer_done;
  // Flopped analog outputs
  logic bias_on;
  logic next_bias_on;
  logic [5:0] eff_ref;
  logic [5:0] next_eff_ref;
  // Write strobe and status view
  logic do_write;
  logic [15:0] merged;
  ars_status_t status;
  default clocking ars_cb @(posedge ref_clk_i); endclocking // Assertion clock
  default disable iff (reset_i);
  // Merge written bytes over the old value
  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [15:0] data, input logic [1:0] strb);
    return {strb[1] ? data[15:8] : old[15:8],
            strb[0] ? data[7:0] : old[7:0]};
  endfunction
  // Channels may only take a new word when free
  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o = !w_held && !bvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;
  assign do_write = aw_held && w_held && !bvalid;
  // Old value of the addressed register for byte merging
  always_comb
  begin
    unique case (aw_idx)
      IDX_REF: merged = merge16({10'h000, ref_sel}, w_data, w_strb);
      IDX_SETTLE: merged = merge16({6'h00, settle_interval_count},
                                   w_data, w_strb);
      IDX_CTRL: merged = merge16({1'b0, ctrl}, w_data, w_strb);
      default: merged = 16'h0000;
    endcase
  end
  // Write channel and register updates
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ref_sel = ref_sel;
    next_settle_interval_count = settle_interval_count;
    next_ctrl = ctrl;
    // Address and data taken in either order
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      next_aw_held = 1'b1;
      next_aw_idx = s_axi_awaddr_i[11:2];
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i[15:0];
      next_w_strb = s_axi_wstrb_i[1:0];
    end
    // Response retired by the master
    if (bvalid && s_axi_bready_i)
      next_bvalid = 1'b0;
    // Both halves held: perform the write
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case (aw_idx)
        IDX_REF: next_ref_sel = merged[REF_LSB +: 6];
        IDX_SETTLE:
          next_settle_interval_count = merged[SETTLE_LSB +: 10];
        IDX_CTRL: next_ctrl = merged[14:0];
        IDX_STATUS: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_DECERR;
      endcase
    end
  end
  // Read channel; data held until the master takes it
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready_i)
      next_rvalid = 1'b0;
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      unique case (s_axi_araddr_i[11:2])
        // Written value, not the effective one
        IDX_REF: next_rdata = {26'h0000000, ref_sel};
        IDX_SETTLE: next_rdata = {22'h000000, settle_interval_count};
        IDX_CTRL: next_rdata = {17'h00000, ctrl};
        IDX_STATUS: next_rdata = {22'h000000, status};
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_DECERR;
        end
      endcase
    end
  end
  // Scan flow: settle, then convert
  always_comb
  begin
    next_state = state;
    timer_start = 1'b0;
    convert_go_o = 1'b0;
    unique case (state)
      ST_IDLE:
        if (scan_request_i)
        begin
          if (settle_interval_count == 10'h000)
          begin
            // No delay wanted
            next_state = ST_CONVERT;
            convert_go_o = 1'b1;
          end
          else
          begin
            // Settle before any conversion
            next_state = ST_SETTLE;
            timer_start = 1'b1;
          end
        end
      ST_SETTLE:
        if (timer_done)
        begin
          next_state = ST_CONVERT;
          convert_go_o = 1'b1;
        end
      ST_CONVERT:
        if (scan_done_i)
          next_state = ST_IDLE;
    endcase
  end
  // Settle interval timer
  ars_settle_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .start_i(timer_start),
    .count_i(settle_interval_count),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );
  // Settle and refresh indications
  assign settle_busy_o = (state == ST_SETTLE);
  assign high_voltage_charge_pump_o = settle_busy_o && !meas_active_i;
  // Effective reference and bias switch
  always_comb
  begin
    // Only enabled analog channels use the bit
    next_eff_ref = ref_sel & ctrl.aux_enable;
    next_eff_ref = next_eff_ref & ~ctrl.pin_general_purpose_enable;
    if (ctrl.two_wire_controller_enable)
      next_eff_ref[1:0] = 2'h0;
    // Auto mode follows the acquisition
    if (ctrl.bias_switch_mode[1])
      next_bias_on = ctrl.bias_switch_mode[0];
    else
      next_bias_on = (next_state != ST_IDLE);
  end
  // Same bit picks reference and threshold set
  assign channel_reference_choice_o = eff_ref;
  assign threshold_set_abs_o = eff_ref;
  assign thermistor_bias_output_o = bias_on;
  // Status view
  assign status = '{effective_ref: eff_ref, bias_on: bias_on,
                    hv_refresh: high_voltage_charge_pump_o,
                    converting: (state == ST_CONVERT),
                    settling: timer_busy};
  // Register all state
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      ref_sel <= REF_RESET;
      settle_interval_count <= SETTLE_RESET;
      ctrl <= CTRL_RESET;
      aw_held <= 1'b0;
      aw_idx <= 10'h000;
      w_held <= 1'b0;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
      state <= ST_IDLE;
      bias_on <= 1'b0;
      eff_ref <= 6'h00;
    end
    else
    begin
      ref_sel <= next_ref_sel;
      settle_interval_count <= next_settle_interval_count;
      ctrl <= next_ctrl;
      aw_held <= next_aw_held;
      aw_idx <= next_aw_idx;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      state <= next_state;
      bias_on <= next_bias_on;
      eff_ref <= next_eff_ref;
    end
  end
  AST_ENABLED_ONLY: assert property (
    (eff_ref & ~$past(ctrl.aux_enable)) == 6'h00)
    else $error("reference applied to disabled channel");
  AST_GPIO_IGNORED: assert property (
    (eff_ref & $past(ctrl.pin_general_purpose_enable)) == 6'h00)
    else $error("reference applied to pin mode channel");
  AST_TWO_WIRE_IGNORED: assert property (
    $past(ctrl.two_wire_controller_enable) |-> eff_ref[1:0] == 2'h0)
    else $error("reference applied under two-wire mode");
  AST_ZERO_SKIP: assert property (
    state == ST_IDLE && scan_request_i && settle_interval_count == 10'h000
    |-> convert_go_o ##1 state == ST_CONVERT)
    else $error("zero settle did not go straight to convert");
  AST_NO_EARLY_CONVERT: assert property (
    state == ST_IDLE && scan_request_i && settle_interval_count == 10'h002
    |=> !convert_go_o [*8] ##292 convert_go_o)
    else $error("conversion not after two settle ticks");
  AST_HV_REFRESH: assert property (
    high_voltage_charge_pump_o == (timer_busy && !meas_active_i))
    else $error("charge pump refresh outside idle settling");
  AST_AUTO_BIAS: assert property (
    state == ST_IDLE && scan_request_i && !ctrl.bias_switch_mode[1]
    |=> bias_on && state != ST_IDLE)
    else $error("auto bias not driven at acquisition start");
  AST_FORCED_BIAS: assert property (
    ctrl.bias_switch_mode == BIAS_FORCE_OFF ##1
    ctrl.bias_switch_mode == BIAS_FORCE_OFF |-> !bias_on)
    else $error("bias on while forced off");
endmodule
`default_nettype wire

// ---- core/ars_settle_timer.sv ----
// Settle interval timer counted in 6 us ticks
`timescale 1ns/1ps
`default_nettype none
module ars_settle_timer
  import ars_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Control
  input wire logic start_i,
  input wire logic [9:0] count_i,
  // Status
  output logic busy_o,
  output logic done_o
);
  logic [7:0] prescale; // Cycles within current tick
  logic [7:0] next_prescale;
  logic [9:0] remain; // Whole ticks still to run
  logic [9:0] next_remain;

  // Tick end on the last cycle of the prescaler
  logic tick_end;
  assign tick_end = (prescale == TICK_LAST);
  assign busy_o = (remain != 10'h000);
  assign done_o = busy_o && tick_end && (remain == 10'h001);

  // Next prescaler and tick count
  always_comb
  begin
    next_prescale = prescale;
    next_remain = remain;
    if (start_i)
    begin
      // Load a fresh interval
      next_prescale = 8'h00;
      next_remain = count_i;
    end
    else if (busy_o)
    begin
      // Count cycles, then whole ticks
      if (tick_end)
      begin
        next_prescale = 8'h00;
        next_remain = remain - 10'h001;
      end
      else
      begin
        next_prescale = prescale + 8'h01;
      end
    end
  end

  // Register state
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      prescale <= 8'h00;
      remain <= 10'h000;
    end
    else
    begin
      prescale <= next_prescale;
      remain <= next_remain;
    end
  end

  AST_TICK_ONE: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    start_i && count_i == 10'h001 |-> ##150 done_o)
    else $error("one tick interval not 150 cycles");
endmodule
`default_nettype wire

// ---- dv/ars_seq_model.sv ----
// Scan sequencer stand-in on the far side of the settle control
`timescale 1ns/1ps
`default_nettype none
module ars_seq_model
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Bench commands
  input wire logic start_i,
  input wire logic busy_i,
  // Block side
  input wire logic convert_go_i,
  output logic scan_request_o,
  output logic scan_done_o,
  output logic meas_active_o
);
  logic [3:0] lag; // Conversion cycles left
  logic [3:0] next_lag;
  logic next_req;
  logic next_done;
  // Request pulse, conversion lag, done pulse
  always_comb
  begin
    next_req = start_i;
    next_done = (lag == 4'h1);
    next_lag = lag;
    if (convert_go_i)
      next_lag = 4'h8;
    else if (lag != 4'h0)
      next_lag = lag - 4'h1;
  end
  // Register sequencer state
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      lag <= 4'h0;
      scan_request_o <= 1'b0;
      scan_done_o <= 1'b0;
    end
    else
    begin
      lag <= next_lag;
      scan_request_o <= next_req;
      scan_done_o <= next_done;
    end
  end
  // Own conversions count as active measurement
  assign meas_active_o = busy_i | (lag != 4'h0);
endmodule
`default_nettype wire

// ---- dv/test_ars_aux_ref_settle.sv ----
// Self-checking bench for the aux reference and settle block
`timescale 1ns/1ps
`default_nettype none
module test_ars_aux_ref_settle
  import ars_pkg::*;
;
  localparam logic [11:0] ADR_REF = {IDX_REF, 2'b00};
  localparam logic [11:0] ADR_SET = {IDX_SETTLE, 2'b00};
  localparam logic [11:0] ADR_CTL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADR_STA = {IDX_STATUS, 2'b00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  // Bus master side
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // Sequencer and analog side
  logic start = 1'b0;
  logic busy = 1'b0;
  logic req, done, meas, cgo, sbusy, high_voltage_charge_pump, bias;
  logic [5:0] cref, tabs;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;

  ars_aux_ref_settle i_ars_aux_ref_settle (
    .ref_clk_i(clk), .reset_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .scan_request_i(req),
    .scan_done_i(done), .meas_active_i(meas), .convert_go_o(cgo),
    .settle_busy_o(sbusy), .high_voltage_charge_pump_o(high_voltage_charge_pump),
    .thermistor_bias_output_o(bias),
    .channel_reference_choice_o(cref), .threshold_set_abs_o(tabs));

  ars_seq_model i_ars_seq_model (
    .ref_clk_i(clk), .reset_i(rst), .start_i(start), .busy_i(busy),
    .convert_go_i(cgo), .scan_request_o(req), .scan_done_o(done),
    .meas_active_o(meas));

  // 25 MHz clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  // Verdict and stop
  task automatic end_sim;
    $display("mismatches=%0d samples_checked=%0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim;
    end
  end

  // Compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One bus write, response code compared
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(negedge clk);
      aw_ok = aw_ok | (awvalid & awready);
      w_ok = w_ok | (wvalid & wready);
      @(posedge clk);
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do @(negedge clk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
    @(posedge clk);
    bready <= 1'b0;
  endtask

  // One bus read, data and code compared
  task automatic rdchk(input logic [11:0] a, input logic [31:0] ed,
                       input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge clk); while (rvalid !== 1'b1);
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // Reference outputs under enables and overrides
  task automatic refs(input logic [5:0] rv, input logic [5:0] en,
                      input logic [5:0] gp, input logic tw);
    logic [5:0] e;
    e = rv & en & ~gp & (tw ? 6'h3c : 6'h3f);
    wr(ADR_REF, 32'(rv), RESP_OKAY);
    wr(ADR_CTL, 32'({2'h2, tw, gp, en}), RESP_OKAY);
    repeat (2) @(negedge clk);
    chk(32'(cref), 32'(e));
    chk(32'(tabs), 32'(e));
    rdchk(ADR_REF, 32'(rv), RESP_OKAY);
    rdchk(ADR_STA, {22'h000000, e, 4'h0}, RESP_OKAY);
  endtask

  // Scan with settle count n, bias mode md, foreign measurement ms
  task automatic scan(input logic [9:0] n, input logic [1:0] md,
                      input logic ms);
    int k;
    logic on;
    on = (md == BIAS_FORCE_ON);
    wr(ADR_SET, 32'(n), RESP_OKAY);
    wr(ADR_CTL, 32'({md, 7'h00, 6'h3f}), RESP_OKAY);
    @(posedge clk);
    busy <= ms;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do @(negedge clk); while (req !== 1'b1);
    chk(32'(bias), 32'(on));
    chk(32'(cgo), 32'(n == 10'h000));
    k = 0;
    while (cgo !== 1'b1)
    begin
      @(negedge clk);
      k++;
      if (k == 1)
      begin
        chk(32'(sbusy), 32'h1);
        chk(32'(high_voltage_charge_pump), 32'(!ms));
        chk(32'(bias), 32'(on | !md[1]));
      end
    end
    chk(32'(k), 32'h96 * 32'(n));
    repeat (14) @(negedge clk);
    chk(32'(sbusy), 32'h0);
    chk(32'(bias), 32'(on));
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdchk(ADR_REF, 32'h0, RESP_OKAY);
    rdchk(ADR_SET, 32'h0, RESP_OKAY);
    wr(ADR_SET, 32'h3ff, RESP_OKAY);
    rdchk(ADR_SET, 32'h3ff, RESP_OKAY);
    wr(12'h000, 32'h1, RESP_DECERR);
    rdchk(12'h000, 32'h0, RESP_DECERR);
    wr(ADR_STA, 32'h3ff, RESP_OKAY);
    refs(6'h3f, 6'h3f, 6'h00, 1'b0);
    refs(6'h2a, 6'h0f, 6'h00, 1'b0);
    refs(6'h3f, 6'h3f, 6'h21, 1'b0);
    refs(6'h3f, 6'h3f, 6'h00, 1'b1);
    scan(10'h000, 2'h0, 1'b0);
    scan(10'h001, 2'h0, 1'b0);
    scan(10'h002, 2'h1, 1'b1);
    scan(10'h001, BIAS_FORCE_OFF, 1'b0);
    scan(10'h001, BIAS_FORCE_ON, 1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
